// ==== core/anx_pkg.sv ====
// constants for the auto-negotiation next page and expansion status bank
package anx_pkg;

	// ------------------------------------------------------------
	// register indices (byte address = 4 * index)
	// ------------------------------------------------------------
	localparam int          IDX_W            = 6;
	localparam logic [5:0]  IDX_NP_RECEIVED  = 6'h05;
	localparam logic [5:0]  IDX_EXPANSION    = 6'h06;
	localparam logic [5:0]  IDX_IRQ_STATUS   = 6'h08;
	localparam logic [5:0]  IDX_IRQ_MASK     = 6'h09;
	localparam int          ADDR_IDX_LSB     = 2;

	// ------------------------------------------------------------
	// received next page field layout
	// ------------------------------------------------------------
	localparam int          NP_FURTHER_BIT   = 15;
	localparam int          NP_ACK_BIT       = 14;
	localparam int          NP_MSG_BIT       = 13;
	localparam int          NP_COMPLY_BIT    = 12;
	localparam int          NP_TOGGLE_BIT    = 11;
	localparam int          NP_CODE_MSB      = 10;
	localparam int          NP_CODE_LSB      = 0;
	localparam logic [15:0] NP_RESET         = 16'h0000;

	// ------------------------------------------------------------
	// expansion register field layout
	// ------------------------------------------------------------
	localparam int          EXP_PD_FAULT_BIT = 4;
	localparam int          EXP_PNP_BIT      = 3;
	localparam int          EXP_LNP_BIT      = 2;
	localparam int          EXP_PAGE_RX_BIT  = 1;
	localparam int          EXP_PAN_BIT      = 0;
	localparam logic        LOCAL_NP_CAPABLE = 1'b1;

	// ------------------------------------------------------------
	// interrupt bits
	// ------------------------------------------------------------
	localparam int          IRQ_W            = 3;
	localparam int          IRQ_PAGE_RX_BIT  = 0;
	localparam int          IRQ_PD_FAULT_BIT = 1;
	localparam int          IRQ_AN_ABLE_BIT  = 2;
	localparam logic [2:0]  IRQ_MASK_RESET   = 3'h0;

	// ------------------------------------------------------------
	// bus encodings
	// ------------------------------------------------------------
	localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
	localparam logic        HRESP_OKAY       = 1'b0;

endpackage

// ==== core/sticky_bits.sv ====
// bank of sticky event bits, cleared by writing one, set wins over clear
`timescale 1ns/1ns
`default_nettype none
module sticky_bits #(
	parameter int WIDTH = 3
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic [WIDTH-1:0] set_pulse,
	input  wire logic [WIDTH-1:0] clear_ones,
	output var  logic [WIDTH-1:0] flags
);

	// ------------------------------------------------------------
	// one flop per bit
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic bit_d;
			assign bit_d = set_pulse[i] | (flags[i] & ~clear_ones[i]); // set wins
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					flags[i] <= 1'b0;
				end else begin
					flags[i] <= bit_d;
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// ==== core/ahb_reg_slave.sv ====
// ahb-lite slave front end with one wait state per transfer
`timescale 1ns/1ns
`default_nettype none
module ahb_reg_slave #(
	parameter int IDX_W = 6
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic             hready,
	input  wire logic [31:0]      hwdata,
	output var  logic             hreadyout,
	output var  logic             hresp,
	output var  logic [31:0]      hrdata,
	output logic                  wr_pulse,
	output logic                  rd_pulse,
	output logic [IDX_W-1:0]      reg_index,
	output logic [31:0]           wr_data,
	input  wire logic [31:0]      rd_data
);

	logic             pending_q;
	logic             write_q;
	logic [IDX_W-1:0] index_q;
	logic             take;

	// ------------------------------------------------------------
	// address phase decode
	// ------------------------------------------------------------
	assign take      = hsel & hready & (htrans == anx_pkg::HTRANS_NONSEQ);
	assign wr_pulse  = pending_q & write_q;
	assign rd_pulse  = pending_q & ~write_q;
	assign reg_index = index_q;
	assign wr_data   = hwdata;

	// capture address phase, ready drops for the first data cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pending_q <= 1'b0;
			write_q   <= 1'b0;
			index_q   <= '0;
			hreadyout <= 1'b1;
			hresp     <= anx_pkg::HRESP_OKAY;
		end else begin
			pending_q <= take;
			hreadyout <= ~take;
			hresp     <= anx_pkg::HRESP_OKAY;
			if (take) begin
				write_q <= hwrite;
				index_q <= haddr[anx_pkg::ADDR_IDX_LSB +: IDX_W];
			end
		end
	end

	// read data registered at the end of the wait cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_pulse) begin
			hrdata <= rd_data;
		end
	end

endmodule
`default_nettype wire

// ==== core/autoneg_next_page_expansion_status.sv ====
// auto-negotiation received next page and expansion status registers
//
// Function
// - bit 13 of the received next page register shows message page (1) or unformatted page (0), read-only, reset 0.
// - bit 12 of the received next page register shows whether the partner can comply with the message.
// - bit 11 of the received next page register shows the toggle value of the received link code word.
// - bits 10:0 of the received next page register hold the partner's 11-bit code, reset all zeros.
// - expansion register bits 15:5 always read zero and writes to them do nothing.
// - expansion bit 4 reads 1 while parallel detection reports a fault, else 0, reset 0.
// - expansion bit 3 reads 1 when the partner supports next page exchange, reset 0.
// - expansion bit 2 always reads 1 since the local device can send next pages, writes ignored.
// - expansion bit 1 is set when a link code word page arrives and clears when the register is read.
// - expansion bit 0 reads 1 when the partner supports auto-negotiation, reset 0.
// - bit 15 of the received next page register reads 1 when the partner requests another next page.
// - bit 14 of the received next page register is the partner acknowledge from the negotiation logic and is never written by software.
`timescale 1ns/1ns
`default_nettype none
module autoneg_next_page_expansion_status (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic [31:0] hrdata,
	// from the negotiation state machine, same clock
	input  wire logic        page_rx_strobe,
	input  wire logic [15:0] page_word,
	input  wire logic        parallel_detect_fault,
	input  wire logic        partner_extra_page_capable,
	input  wire logic        partner_negotiation_capable,
	// interrupt
	output var  logic        irq
);

	// ------------------------------------------------------------
	// bus front end
	// ------------------------------------------------------------
	logic                      wr_pulse;
	logic                      rd_pulse;
	logic [anx_pkg::IDX_W-1:0] reg_index;
	logic [31:0]               wr_data;
	logic [31:0]               rd_data;

	ahb_reg_slave #(
		.IDX_W (anx_pkg::IDX_W)
	) u_bus (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.hwdata    (hwdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.wr_pulse  (wr_pulse),
		.rd_pulse  (rd_pulse),
		.reg_index (reg_index),
		.wr_data   (wr_data),
		.rd_data   (rd_data)
	);

	// ------------------------------------------------------------
	// register selects
	// ------------------------------------------------------------
	wire sel_np   = (reg_index == anx_pkg::IDX_NP_RECEIVED);
	wire sel_exp  = (reg_index == anx_pkg::IDX_EXPANSION);
	wire sel_ists = (reg_index == anx_pkg::IDX_IRQ_STATUS);
	wire sel_imsk = (reg_index == anx_pkg::IDX_IRQ_MASK);
	wire rd_exp   = rd_pulse & sel_exp;

	// ------------------------------------------------------------
	// received next page register
	// ------------------------------------------------------------
	logic [15:0] np_received_q;

	// whole word loads at once on each received page, no software write path
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			np_received_q <= anx_pkg::NP_RESET;
		end else if (page_rx_strobe) begin
			np_received_q <= page_word;
		end
	end

	wire further_page_request = np_received_q[anx_pkg::NP_FURTHER_BIT];
	wire partner_ack          = np_received_q[anx_pkg::NP_ACK_BIT];
	wire message_page_flag    = np_received_q[anx_pkg::NP_MSG_BIT];
	wire partner_comply_ack   = np_received_q[anx_pkg::NP_COMPLY_BIT];
	wire toggle_flag          = np_received_q[anx_pkg::NP_TOGGLE_BIT];
	wire [10:0] page_code     = np_received_q[anx_pkg::NP_CODE_MSB:anx_pkg::NP_CODE_LSB];

	wire [15:0] np_view = {further_page_request, partner_ack, message_page_flag,
		partner_comply_ack, toggle_flag, page_code};

	// ------------------------------------------------------------
	// expansion status flops
	// ------------------------------------------------------------
	logic pd_fault_q;
	logic partner_np_q;
	logic partner_an_q;
	logic page_rx_q;
	logic page_rx_d;

	// page flag: new page sets, read of expansion clears, set wins
	assign page_rx_d = page_rx_strobe | (page_rx_q & ~rd_exp);

	// capture the status levels reported by the negotiation logic
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pd_fault_q   <= 1'b0;
			partner_np_q <= 1'b0;
			partner_an_q <= 1'b0;
			page_rx_q    <= 1'b0;
		end else begin
			pd_fault_q   <= parallel_detect_fault;
			partner_np_q <= partner_extra_page_capable;
			partner_an_q <= partner_negotiation_capable;
			page_rx_q    <= page_rx_d;
		end
	end

	// upper bits tied low, local capability constant
	wire [15:0] exp_view = {11'h000, pd_fault_q, partner_np_q,
		anx_pkg::LOCAL_NP_CAPABLE, page_rx_q, partner_an_q};

	// ------------------------------------------------------------
	// interrupt events, status and mask
	// ------------------------------------------------------------
	logic [anx_pkg::IRQ_W-1:0] irq_status;
	logic [anx_pkg::IRQ_W-1:0] irq_mask_q;
	logic [anx_pkg::IRQ_W-1:0] irq_events;
	logic [anx_pkg::IRQ_W-1:0] irq_clear;

	// page arrival, fault rising edge, partner negotiation rising edge
	assign irq_events[anx_pkg::IRQ_PAGE_RX_BIT]  = page_rx_strobe;
	assign irq_events[anx_pkg::IRQ_PD_FAULT_BIT] = parallel_detect_fault & ~pd_fault_q;
	assign irq_events[anx_pkg::IRQ_AN_ABLE_BIT]  = partner_negotiation_capable & ~partner_an_q;
	assign irq_clear = (wr_pulse & sel_ists) ? wr_data[anx_pkg::IRQ_W-1:0] : '0;

	sticky_bits #(
		.WIDTH (anx_pkg::IRQ_W)
	) u_irq_status (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.set_pulse  (irq_events),
		.clear_ones (irq_clear),
		.flags      (irq_status)
	);

	// mask register and registered interrupt level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask_q <= anx_pkg::IRQ_MASK_RESET;
			irq        <= 1'b0;
		end else begin
			if (wr_pulse & sel_imsk) begin
				irq_mask_q <= wr_data[anx_pkg::IRQ_W-1:0];
			end
			irq <= |(irq_status & irq_mask_q);
		end
	end

	// ------------------------------------------------------------
	// read mux, unmapped reads return zero
	// ------------------------------------------------------------
	assign rd_data = sel_np   ? {16'h0000, np_view} :
	                 sel_exp  ? {16'h0000, exp_view} :
	                 sel_ists ? {29'h0000_0000, irq_status} :
	                 sel_imsk ? {29'h0000_0000, irq_mask_q} :
	                 32'h0000_0000;

endmodule
`default_nettype wire

// ==== tb/anx_properties.sv ====
// concurrent checks on the status bank's bus and register ports
`timescale 1ns/1ns
`default_nettype none
module anx_properties (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        page_rx_strobe,
	input wire logic [15:0] page_word,
	input wire logic        parallel_detect_fault,
	input wire logic        partner_extra_page_capable,
	input wire logic        partner_negotiation_capable,
	input wire logic        irq
);
	// transfer decode
	wire logic       take   = hsel && hready && htrans == anx_pkg::HTRANS_NONSEQ;
	wire logic [5:0] idx    = haddr[7:2];
	wire logic       rd_any = take && !hwrite;
	wire logic       rd_np  = rd_any && idx == anx_pkg::IDX_NP_RECEIVED;
	wire logic       rd_exp = rd_any && idx == anx_pkg::IDX_EXPANSION;
	logic [15:0]     np_q;
	logic            pr_q;
	logic            pend_q;

	// shadow of the received word and the page flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			np_q <= 16'h0000;
			pr_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			pend_q <= rd_exp;
			if (page_rx_strobe) begin
				np_q <= page_word;
				pr_q <= 1'b1;
			end else if (pend_q) begin
				pr_q <= 1'b0;
			end
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_one_wait: assert property (take |=> !hreadyout ##1 hreadyout)
		else $error("wait state not exactly one");
	a_ready_idle: assert property (!take && hreadyout |=> hreadyout)
		else $error("ready dropped without transfer");
	a_resp_okay: assert property (hresp == anx_pkg::HRESP_OKAY)
		else $error("response not okay");
	a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_any, 2))
		else $error("read data moved without read");
	a_upper_zero: assert property (rd_any |=> ##1 hrdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	a_np_fields: assert property (rd_np |=> ##1 hrdata[15:0] == $past(np_q))
		else $error("next page word wrong");
	a_exp_fields: assert property (rd_exp |=> ##1 hrdata[15:2] == {11'h000,
		$past(parallel_detect_fault, 2), $past(partner_extra_page_capable, 2), 1'b1})
		else $error("expansion fields wrong");
	a_partner_an: assert property (rd_exp |=> ##1 hrdata[0] == $past(partner_negotiation_capable, 2))
		else $error("partner negotiation bit wrong");
	a_page_flag: assert property (rd_exp |=> ##1 hrdata[1] == $past(pr_q))
		else $error("page received flag wrong");

	c_np_read: cover property (rd_np);
	c_page_read: cover property (page_rx_strobe ##[1:20] rd_exp);
	c_irq: cover property ($rose(irq));
endmodule
bind autoneg_next_page_expansion_status anx_properties i_props (.*);
`default_nettype wire

// ==== tb/link_partner_model.sv ====
// far-side negotiation logic delivering received link code words
`timescale 1ns/1ns
`default_nettype none
module link_partner_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        send_req,
	input  wire logic [15:0] send_word,
	output logic             page_rx_strobe,
	output logic [15:0]      page_word
);
	// one-cycle strobe with word; between words the bus churns
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			page_rx_strobe <= 1'b0;
			page_word <= 16'h0000;
		end else begin
			page_rx_strobe <= send_req;
			page_word <= send_req ? send_word : ~page_word;
		end
	end
endmodule
`default_nettype wire

// ==== tb/autoneg_next_page_expansion_status_bench.sv ====
// self-checking bench for the next page and expansion status bank
`timescale 1ns/1ns
`default_nettype none
module autoneg_next_page_expansion_status_bench;
	localparam logic [5:0] NPR = anx_pkg::IDX_NP_RECEIVED;
	localparam logic [5:0] EXP = anx_pkg::IDX_EXPANSION;
	localparam logic [5:0] IST = anx_pkg::IDX_IRQ_STATUS;
	localparam logic [5:0] IMK = anx_pkg::IDX_IRQ_MASK;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, send_req;
	logic        parallel_detect_fault, partner_extra_page_capable;
	logic        partner_negotiation_capable, page_rx_strobe;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [15:0] send_word, page_word;
	wire logic   hready = hreadyout;
	int          fail_count, compares;

	autoneg_next_page_expansion_status i_dut (.*, .hsize(3'h2));
	link_partner_model i_partner (.*);

	// free-running bus clock
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	// ----
	// bus and compare helpers
	// ----
	task stop_test;
		$display("compares %0d, wrong %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) begin
			fail_count++;
			stop_test;
		end
	endtask
	task bus(input logic w, input logic [5:0] idx, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= anx_pkg::HTRANS_NONSEQ;
		haddr <= {24'h000000, idx, 2'h0};
		hwrite <= w;
		wait_ready;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready;
		rd = hrdata;
	endtask
	task rchk(input logic [5:0] idx, input logic [31:0] e);
		bus(1'b0, idx, 32'h0);
		chk(rd, e);
	endtask
	task page(input logic [15:0] w);
		send_req <= 1'b1;
		send_word <= w;
		@(posedge hclk);
		send_req <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask

	// ----
	// scenarios
	// ----
	task t_reset;
		rchk(EXP, 32'h4);
		rchk(NPR, 32'h0);
		rchk(6'h3f, 32'h0);
		$display("test reset done");
	endtask
	task t_page;
		page(16'ha955);
		rchk(EXP, 32'h6);
		rchk(NPR, 32'ha955);
		rchk(EXP, 32'h4);
		page(16'h56aa);
		rchk(NPR, 32'h56aa);
		$display("test page done");
	endtask
	task t_status;
		parallel_detect_fault <= 1'b1;
		partner_extra_page_capable <= 1'b1;
		partner_negotiation_capable <= 1'b1;
		@(posedge hclk);
		rchk(EXP, 32'h1f);
		bus(1'b1, EXP, 32'hffffffff);
		rchk(EXP, 32'h1d);
		parallel_detect_fault <= 1'b0;
		partner_extra_page_capable <= 1'b0;
		partner_negotiation_capable <= 1'b0;
		@(posedge hclk);
		rchk(EXP, 32'h4);
		$display("test status done");
	endtask
	task t_irq;
		bus(1'b1, IST, 32'h7);
		bus(1'b1, IMK, 32'h1);
		page(16'h0001);
		chk({31'h0, irq}, 32'h1);
		rchk(IST, 32'h1);
		bus(1'b1, IST, 32'h1);
		@(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, IMK, 32'h0);
		page(16'h0002);
		chk({31'h0, irq}, 32'h0);
		rchk(IST, 32'h1);
		$display("test irq done");
	endtask

	// reset, then the scenarios in turn
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		send_req = 1'b0;
		send_word = 16'h0;
		parallel_detect_fault = 1'b0;
		partner_extra_page_capable = 1'b0;
		partner_negotiation_capable = 1'b0;
		fail_count = 0;
		compares = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_page;
		t_status;
		t_irq;
		stop_test;
	end
endmodule
`default_nettype wire
